/* File: common/spd_pkg.sv */
// package of constants for the serial converter power-down control block
package spd_pkg;
  localparam int unsigned SPD_RESULT_W = 10;
  localparam int unsigned SPD_LEAD_ZEROS = 4;
  localparam int unsigned SPD_TRAIL_ZEROS = 2;
  localparam int unsigned SPD_FRAME_EDGES = 16;
  localparam logic [4:0] SPD_PD_FIRST_EDGE = 5'h02;
  localparam logic [4:0] SPD_PD_LAST_EDGE = 5'h0a;
  localparam logic [4:0] SPD_WAKE_EDGES = 5'h0a;
  localparam logic [4:0] SPD_RELEASE_EDGE = 5'h10;
  localparam logic [4:0] SPD_CONV_END_EDGE = 5'h0e;
  localparam int unsigned SPD_SYS_CLK_MHZ = 250;
  localparam int unsigned SPD_SETTLE_NS = 800;
  localparam int unsigned SPD_SETTLE_CYC = (SPD_SETTLE_NS * SPD_SYS_CLK_MHZ + 999) / 1000;
  localparam int unsigned SPD_SETTLE_W = 10;
  localparam logic [SPD_SETTLE_W-1:0] SPD_SETTLE_CNT = SPD_SETTLE_W'(SPD_SETTLE_CYC);
  typedef enum logic [1:0] {
    SPD_PWR_ON,
    SPD_PWR_DOWN,
    SPD_PWR_WAKING
  } spd_pwr_type;
endpackage

/* File: rtl/spd_sync.sv */
// two-flop level synchroniser
`timescale 1ns/1ps
`default_nettype none
module spd_sync #(
  parameter logic RESET_VAL = 1'b0
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic d_i,
  output logic q_o
);
  logic meta_q;
  // first stage is read only by the second stage
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta_q <= RESET_VAL;
      q_o <= RESET_VAL;
    end else begin
      meta_q <= d_i;
      q_o <= meta_q;
    end
  end
endmodule // spd_sync
`default_nettype wire

/* File: rtl/spd_ctrl.sv */
// serial converter link: frame shifting, power-down entry and wake-up settling
//
// Summary of operation
// - chip select high between edges 2 and 10 powers down
// - power-down aborts conversion, data output floats
// - chip select low for ten or more edges wakes device
// - settling 0.8 us counted from chip select fall
// - chip select fall samples input, starts conversion
// - frame is 4 zeros, 10 bits msb first, 2 zeros
// - data output floats on edge 16
// - chip select high aborts conversion, output floats
`timescale 1ns/1ps
`default_nettype none
module spd_ctrl
  import spd_pkg::*;
#(
  parameter int unsigned RESULT_W = SPD_RESULT_W
) (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic serial_clk_i,
  input wire logic chip_select_n_i,
  input wire logic [RESULT_W-1:0] sample_i,
  output logic serial_data_out_o,
  output logic serial_data_out_oe_o,
  output logic sample_strobe_o,
  output logic powered_down_o,
  output logic fully_powered_o,
  output logic converting_o
);
  ////////////////////////////////////////////////////////////////////////////
  // timing overview
  // frame position p is the count of serial clock falls since chip select fell.
  // position 0 shows the first lead zero, position 4 the msb, and the enable
  // drops once position 16 is reached.
  // the link state crosses into the system domain through two flops and one
  // output register, so the pins lag the link by two to three system clocks.
  // limitation: each link level must stand for at least three system clocks,
  // which holds for any serial clock slower than a third of the system clock.
  // trade-off: a level crossing is used for data and enable instead of a
  // handshake, because the frame is slow and one bit wide.

  ////////////////////////////////////////////////////////////////////////////
  // link domain: edge counter and shifter on serial clock falling edges
  // there is no reset pin on the link; a chip select high clears the frame
  // asynchronously, so a stopped serial clock never strands the output.
  // the system reset also clears the link flops; this is safe because the
  // host keeps chip select high and the serial clock still while it is applied.
  localparam int unsigned SHIFT_W = SPD_LEAD_ZEROS - 1 + RESULT_W + SPD_TRAIL_ZEROS;
  logic [4:0] edge_cnt_q;
  logic [SHIFT_W-1:0] shift_q;
  logic done_q;
  logic oe_link;
  logic frame_tgl_q;
  logic pd_tgl_q;
  logic wake_tgl_q;
  logic [RESULT_W-1:0] cap_q;
  logic link_pd_q;

  // power-down entry is judged when chip select rises; its own edge closes the frame
  always_ff @(posedge chip_select_n_i or posedge rst_i) begin
    if (rst_i) begin
      pd_tgl_q <= 1'b0;
      wake_tgl_q <= 1'b0;
      link_pd_q <= 1'b0;
    end else if (edge_cnt_q >= SPD_PD_FIRST_EDGE && edge_cnt_q < SPD_PD_LAST_EDGE) begin
      pd_tgl_q <= ~pd_tgl_q;
      link_pd_q <= 1'b1;
    end else if (edge_cnt_q > SPD_WAKE_EDGES - 5'h01 && link_pd_q) begin
      wake_tgl_q <= ~wake_tgl_q;
      link_pd_q <= 1'b0;
    end
  end

  // edge count and release flag; chip select high holds the frame cleared
  // the count saturates so a long frame can never wrap back into the window
  always_ff @(negedge serial_clk_i or posedge chip_select_n_i or posedge rst_i) begin
    if (chip_select_n_i || rst_i) begin
      edge_cnt_q <= 5'h00;
      done_q <= 1'b0;
    end else begin
      if (edge_cnt_q != 5'h1f) begin
        edge_cnt_q <= edge_cnt_q + 5'h01;
      end
      if (edge_cnt_q >= SPD_RELEASE_EDGE - 5'h01) begin
        done_q <= 1'b1;
      end
    end
  end

  // the pin is driven from chip select fall until release, never in power-down
  assign oe_link = !chip_select_n_i && !done_q && !link_pd_q;

  // chip select fall samples the input and marks a new frame
  always_ff @(negedge chip_select_n_i or posedge rst_i) begin
    if (rst_i) begin
      cap_q <= '0;
      frame_tgl_q <= 1'b0;
    end else begin
      cap_q <= sample_i;
      frame_tgl_q <= ~frame_tgl_q;
    end
  end

  // shift register: position 0 is the cleared zero; fall 1 loads positions 1 to 15
  // so the msb leaves on fall 4 and the two trailing zeros follow the lsb
  always_ff @(negedge serial_clk_i or posedge chip_select_n_i or posedge rst_i) begin
    if (chip_select_n_i || rst_i) begin
      shift_q <= '0;
    end else if (edge_cnt_q == 5'h00) begin
      shift_q <= {{(SPD_LEAD_ZEROS-1){1'b0}}, cap_q, {SPD_TRAIL_ZEROS{1'b0}}};
    end else begin
      shift_q <= {shift_q[SHIFT_W-2:0], 1'b0};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // system domain: crossings and status
  logic frame_s;
  logic pd_s;
  logic wake_s;
  logic cs_n_s;
  logic oe_s;
  logic data_s;
  logic frame_d_q;
  logic pd_d_q;
  logic wake_d_q;
  logic cs_n_d_q;
  spd_pwr_type pwr_q;
  logic [SPD_SETTLE_W-1:0] settle_q;

  spd_sync #(.RESET_VAL(1'b0)) u_sync_frame (.clk_i(sys_clk_i), .rst_i(rst_i), .d_i(frame_tgl_q), .q_o(frame_s));
  spd_sync #(.RESET_VAL(1'b0)) u_sync_pd (.clk_i(sys_clk_i), .rst_i(rst_i), .d_i(pd_tgl_q), .q_o(pd_s));
  spd_sync #(.RESET_VAL(1'b0)) u_sync_wake (.clk_i(sys_clk_i), .rst_i(rst_i), .d_i(wake_tgl_q), .q_o(wake_s));
  spd_sync #(.RESET_VAL(1'b1)) u_sync_cs (.clk_i(sys_clk_i), .rst_i(rst_i), .d_i(chip_select_n_i), .q_o(cs_n_s));
  // pin enable and data are levels that stand a whole serial clock period
  spd_sync #(.RESET_VAL(1'b0)) u_sync_oe (.clk_i(sys_clk_i), .rst_i(rst_i), .d_i(oe_link), .q_o(oe_s));
  spd_sync #(.RESET_VAL(1'b0)) u_sync_data (.clk_i(sys_clk_i), .rst_i(rst_i), .d_i(shift_q[SHIFT_W-1]), .q_o(data_s));

  // delayed copies for toggle and edge detection
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      frame_d_q <= 1'b0;
      pd_d_q <= 1'b0;
      wake_d_q <= 1'b0;
      cs_n_d_q <= 1'b1;
    end else begin
      frame_d_q <= frame_s;
      pd_d_q <= pd_s;
      wake_d_q <= wake_s;
      cs_n_d_q <= cs_n_s;
    end
  end

  // power state; settling counts from the dummy cycle's chip select fall
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      pwr_q <= SPD_PWR_ON;
      settle_q <= '0;
    end else begin
      unique case (pwr_q)
        SPD_PWR_ON: begin
          if (pd_s != pd_d_q) begin
            pwr_q <= SPD_PWR_DOWN;
          end
        end
        SPD_PWR_DOWN: begin
          if (cs_n_d_q && !cs_n_s) begin
            settle_q <= SPD_SETTLE_CNT - 1'b1;
          end else if (settle_q != '0) begin
            settle_q <= settle_q - 1'b1;
          end
          if (wake_s != wake_d_q) begin
            pwr_q <= SPD_PWR_WAKING;
          end
        end
        SPD_PWR_WAKING: begin
          if (settle_q == '0) begin
            pwr_q <= SPD_PWR_ON;
          end else begin
            settle_q <= settle_q - 1'b1;
          end
        end
      endcase
    end
  end

  // registered outputs; the pin copy is retimed, so it lags the link by up to three clocks
  // the data is gated by the enable so a floating pin always reads as zero here
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      serial_data_out_o <= 1'b0;
      serial_data_out_oe_o <= 1'b0;
      sample_strobe_o <= 1'b0;
      powered_down_o <= 1'b0;
      fully_powered_o <= 1'b1;
      converting_o <= 1'b0;
    end else begin
      serial_data_out_o <= data_s & oe_s;
      serial_data_out_oe_o <= oe_s;
      sample_strobe_o <= (frame_s != frame_d_q);
      powered_down_o <= (pwr_q == SPD_PWR_DOWN);
      fully_powered_o <= (pwr_q == SPD_PWR_ON);
      converting_o <= !cs_n_s && (pwr_q == SPD_PWR_ON);
    end
  end
endmodule // spd_ctrl
`default_nettype wire

/* File: tb/spd_ctrl_asserts.sv */
// port checker for the power-down control block
`timescale 1ns/1ps
`default_nettype none
module spd_ctrl_asserts (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic chip_select_n_i,
  input wire logic serial_data_out_o,
  input wire logic serial_data_out_oe_o,
  input wire logic sample_strobe_o,
  input wire logic powered_down_o,
  input wire logic fully_powered_o,
  input wire logic converting_o
);
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (rst_i);
  // status outputs are registered, so power-down effects are judged one cycle after entry
  a_strobe_on_fall: assert property ($fell(chip_select_n_i) && !powered_down_o |-> ##[1:5] sample_strobe_o)
    else $error("no strobe after select fall");
  a_strobe_single: assert property (sample_strobe_o |=> !sample_strobe_o)
    else $error("strobe too long");
  a_pd_floats: assert property (powered_down_o [*2] |-> !serial_data_out_oe_o && !fully_powered_o)
    else $error("pin driven in power-down");
  a_pd_no_conv: assert property (powered_down_o [*2] |-> !converting_o)
    else $error("converting in power-down");
  a_cs_high_floats: assert property (chip_select_n_i [*6] |-> !serial_data_out_oe_o && !converting_o)
    else $error("pin driven with select high");
  a_lead_zero: assert property ($rose(serial_data_out_oe_o) |-> !serial_data_out_o)
    else $error("frame starts with one");
  a_wake_not_early: assert property ($fell(powered_down_o) |-> !fully_powered_o ##1 !fully_powered_o)
    else $error("settled too early");
  a_wake_bound: assert property ($fell(powered_down_o) |-> ##[1:220] fully_powered_o)
    else $error("never settled");
  c_pd_entry: cover property ($rose(powered_down_o));
  c_wake: cover property ($rose(fully_powered_o));
  c_frame: cover property ($fell(serial_data_out_oe_o) && !powered_down_o);
endmodule // spd_ctrl_asserts
bind spd_ctrl spd_ctrl_asserts i_asserts (.sys_clk_i, .rst_i, .chip_select_n_i, .serial_data_out_o,
  .serial_data_out_oe_o, .sample_strobe_o, .powered_down_o, .fully_powered_o, .converting_o);
`default_nettype wire

/* File: tb/spd_host.sv */
// host model driving chip select and the serial clock
`timescale 1ns/1ps
`default_nettype none
module spd_host (
  output logic serial_clk_o,
  output logic chip_select_n_o
);
  // clock stands high between frames so no stray fall is counted
  initial begin
    serial_clk_o = 1'b1;
    chip_select_n_o = 1'b1;
  end
  // one frame of a given count of falls; the gap covers quiet time and settling
  task automatic run(input int falls, input int tail, input int gap);
    chip_select_n_o = 1'b0;
    #15; // a full period before the first fall so the first zero stands as long as the rest
    repeat (falls) begin
      serial_clk_o = 1'b0;
      #7.5;
      serial_clk_o = 1'b1;
      #7.5;
    end
    #(tail);
    chip_select_n_o = 1'b1;
    #(gap);
  endtask
endmodule // spd_host
`default_nettype wire

/* File: tb/spd_ctrl_tb.sv */
// self-checking bench for the power-down control block
`timescale 1ns/1ps
`default_nettype none
module spd_ctrl_tb import spd_pkg::*; ;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic [SPD_RESULT_W-1:0] sample = 10'h000;
  wire logic sclk, cs_n, serial_data_out, oe, strobe, pd, full, conv;
  int fail_count = 0;
  int compares = 0;
  spd_ctrl i_dut (.sys_clk_i(sys_clk), .rst_i(rst), .serial_clk_i(sclk), .chip_select_n_i(cs_n), .sample_i(sample),
    .serial_data_out_o(serial_data_out), .serial_data_out_oe_o(oe), .sample_strobe_o(strobe), .powered_down_o(pd),
    .fully_powered_o(full), .converting_o(conv));
  spd_host i_host (.serial_clk_o(sclk), .chip_select_n_o(cs_n));
  initial begin
    forever #2 sys_clk = ~sys_clk;
  end
  task automatic chk(input logic got, input logic want);
    compares++;
    if (got !== want) begin
      fail_count++;
      $display("unexpected at %0t: got %h exp %h", $time, got, want);
    end
  endtask
  task automatic close_out();
    if (fail_count == 0 && compares > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // 3 ns after fall j the retimed pin still shows frame position j-1
  task automatic frame_check(input logic [9:0] val);
    @(negedge sys_clk);
    sample = val;
    fork
      i_host.run(16, 40, 200);
      for (int j = 1; j <= 16; j++) begin
        @(negedge sclk);
        #3;
        chk(oe, 1'b1);
        chk(serial_data_out, (j > 4 && j <= 14) ? val[14-j] : 1'b0);
        if (j == 8) begin
          chk(conv, 1'b1);
        end
      end
    join_any
    #27;
    chk(oe, 1'b0);
    wait (cs_n);
    #200;
  endtask
  // select raised after a count of falls; only 2..9 enters power-down
  task automatic entry_check(input int falls);
    logic want;
    want = (falls >= 2 && falls <= 9);
    i_host.run(falls, 8, 100);
    chk(pd, want);
    chk(oe, 1'b0);
    if (want) begin
      i_host.run(10, 8, 600);
      chk(full, 1'b0);
      #150;
      chk(pd, 1'b0);
      chk(full, 1'b1);
    end
  endtask
  initial begin
    repeat (12) @(posedge sys_clk);
    @(negedge sys_clk);
    rst = 1'b0;
    repeat (4) @(negedge sys_clk);
    frame_check(10'h2b5);
    frame_check(10'h3ff);
    entry_check(1);
    entry_check(2);
    entry_check(9);
    entry_check(10);
    entry_check(12);
    frame_check(10'h001);
    close_out();
  end
  // the sequence needs under 10 us
  initial begin
    #50000;
    fail_count++;
    close_out();
  end
endmodule // spd_ctrl_tb
`default_nettype wire
